/* design/urbs_pkg.sv */
// constants, field positions and state codes of the receive buffer and status block
package urbs_pkg;
   // register byte addresses on the apb bus
   localparam logic [11:0] ADDR_DATA = 12'h000;
   localparam logic [11:0] ADDR_CSA = 12'h004;
   localparam logic [11:0] ADDR_CSB = 12'h008;
   localparam logic [11:0] ADDR_FMT = 12'h00C;

   // ctrl_status_a bit positions
   localparam int CSA_RXC = 7;
   localparam int CSA_FE = 4;
   localparam int CSA_DOR = 3;
   localparam int CSA_UPE = 2;

   // ctrl_status_b bit positions and writable bits
   localparam int CSB_RXCIE = 7;
   localparam int CSB_RXEN = 4;
   localparam int CSB_SIZE2 = 2;
   localparam int CSB_RXB8 = 1;
   localparam logic [7:0] CSB_WMASK = 8'h94;
   localparam logic [7:0] CSB_RST = 8'h00;

   // frame_format_register bit positions and writable bits
   localparam int FMT_UPM1 = 5;
   localparam int FMT_UPM0 = 4;
   localparam int FMT_USBS = 3;
   localparam int FMT_SIZE1 = 2;
   localparam int FMT_SIZE0 = 1;
   localparam logic [7:0] FMT_WMASK = 8'h3E;
   localparam logic [7:0] FMT_RST = 8'h06;

   // character size code for nine data bits
   localparam logic [2:0] SIZE_NINE = 3'h7;
   localparam logic [3:0] BITS_NINE = 4'h9;
   localparam logic [3:0] BITS_MIN = 4'h5;

   // buffer entry layout
   localparam int ENT_W = 12;
   localparam int ENT_FE = 11;
   localparam int ENT_DOR = 10;
   localparam int ENT_UPE = 9;
   localparam int ENT_B8 = 8;
   localparam logic [1:0] CNT_FULL = 2'h2;

   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_DATA = 5'b00010,
      ST_PAR = 5'b00100,
      ST_STOP = 5'b01000,
      ST_HOLD = 5'b10000
   } urbs_state_t;
endpackage

/* design/urbs_rx_mem.sv */
// two-entry receive buffer storage with registered read data
module urbs_rx_mem (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic wr_en,
   input wire logic wr_addr,
   input wire logic [urbs_pkg::ENT_W-1:0] wr_data,
   input wire logic rd_addr,
   output logic [urbs_pkg::ENT_W-1:0] rd_data
);
   logic [urbs_pkg::ENT_W-1:0] mem_r [0:1];

   // storage needs no reset; the fill count decides what is valid
   always_ff @(posedge pclk) begin
      for (int i = 0; i < 2; i++) begin
         if (wr_en && (wr_addr == i[0])) begin
            mem_r[i] <= wr_data;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_data <= '0;
      end else begin
         rd_data <= mem_r[rd_addr];
      end
   end
endmodule

/* design/urbs_rx_status.sv */
// receive shift register, two-entry buffer, status flags and apb registers of the serial receiver
//
// Notes on behaviour
// - receive-complete flag is high exactly while the buffer holds an unread character.
// - clearing the receive enable bit empties the buffer, so receive-complete drops.
// - interrupt requested while flag, its enable and the global enable are all set.
// - error flags travel in the buffer with their frame; data reads advance them.
// - software writes to the three error flag positions are ignored.
// - error flags never raise an interrupt.
// - frame error shows 0 for a first stop bit of one, 1 for zero.
// - only the first stop bit is checked; stop-bit count setting is ignored.
// - overrun when a start arrives with buffer full and a frame waiting.
// - overrun pending clears when a frame moves from shift register to buffer.
// - parity error reads zero while parity checking is disabled.
// - upper parity mode bit enables checking, lower bit chooses odd or even.
// - checker compares data parity with received parity bit and buffers the result.
// - parity error set only for failed frames checked while enabled; valid until read.
// - disabling the receiver is immediate, dropping reception and buffered characters.
// - while disabled the receiver releases its override of the receive pin.
// - the ninth bit is buffered with each frame and read from ctrl_status_b.
// - on the first stop bit the completed frame moves into the buffer if it has room, else once a read frees space.
// - unused high data bits of short characters read as zero.
module urbs_rx_status (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_start_det,
   input wire logic rx_bit_strobe,
   input wire logic rx_bit_value,
   input wire logic global_irq_enable,
   output logic rx_irq,
   output logic rx_pin_override
);
   logic [7:0] csb_r;
   logic [7:0] fmt_r;
   urbs_pkg::urbs_state_t state_r;
   logic [8:0] shr_r;
   logic [3:0] bit_cnt_r;
   logic par_acc_r;
   logic upe_hold_r;
   logic fe_hold_r;
   logic dor_pend_r;
   logic [1:0] count_r;
   logic wptr_r;
   logic rptr_r;
   logic [urbs_pkg::ENT_W-1:0] head;
   logic wr_en;
   logic fe_now;
   logic [urbs_pkg::ENT_W-1:0] wr_data;
   logic access;
   logic fire;
   logic wr_fire;
   logic pop;
   logic rxen;
   logic rxc;
   logic upm1;
   logic [2:0] size_code;
   logic room;

   function automatic logic is_mapped(input logic [11:0] a);
      is_mapped = (a == urbs_pkg::ADDR_DATA) || (a == urbs_pkg::ADDR_CSA) ||
                  (a == urbs_pkg::ADDR_CSB) || (a == urbs_pkg::ADDR_FMT);
   endfunction

   function automatic logic [3:0] char_bits(input logic [2:0] code);
      if (code == urbs_pkg::SIZE_NINE) begin
         char_bits = urbs_pkg::BITS_NINE;
      end else begin
         char_bits = urbs_pkg::BITS_MIN + {2'h0, code[1:0]};
      end
   endfunction

   assign rxen = csb_r[urbs_pkg::CSB_RXEN];
   assign upm1 = fmt_r[urbs_pkg::FMT_UPM1];
   assign size_code = {csb_r[urbs_pkg::CSB_SIZE2], fmt_r[urbs_pkg::FMT_SIZE1], fmt_r[urbs_pkg::FMT_SIZE0]};
   assign rxc = (count_r != 2'h0);
   assign room = (count_r != urbs_pkg::CNT_FULL);

   // apb: setup, one wait cycle in access, then pready for one cycle
   assign access = psel && penable;
   assign fire = access && pready;
   assign wr_fire = fire && pwrite;
   // a data read on an empty buffer pops nothing
   assign pop = fire && !pwrite && (paddr == urbs_pkg::ADDR_DATA) && rxc && rxen;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= access && !pready;
      end
   end

   // read data is captured a cycle before completion so the registered head has settled
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (access && !pready) begin
         pslverr <= !is_mapped(paddr);
         prdata <= 32'h0000_0000;
         if (!pwrite) begin
            unique case (paddr)
               urbs_pkg::ADDR_DATA: prdata[7:0] <= rxc ? head[7:0] : 8'h00;
               urbs_pkg::ADDR_CSA: begin
                  prdata[urbs_pkg::CSA_RXC] <= rxc;
                  prdata[urbs_pkg::CSA_FE] <= rxc && head[urbs_pkg::ENT_FE];
                  prdata[urbs_pkg::CSA_DOR] <= rxc && head[urbs_pkg::ENT_DOR];
                  prdata[urbs_pkg::CSA_UPE] <= rxc && upm1 && head[urbs_pkg::ENT_UPE];
               end
               urbs_pkg::ADDR_CSB: begin
                  prdata[7:0] <= csb_r;
                  prdata[urbs_pkg::CSB_RXB8] <= rxc && head[urbs_pkg::ENT_B8];
               end
               urbs_pkg::ADDR_FMT: prdata[7:0] <= fmt_r;
               default: prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // status a has no writable bits, so error flags cannot be altered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         csb_r <= urbs_pkg::CSB_RST;
         fmt_r <= urbs_pkg::FMT_RST;
      end else if (wr_fire) begin
         if (paddr == urbs_pkg::ADDR_CSB) begin
            csb_r <= pwdata[7:0] & urbs_pkg::CSB_WMASK;
         end
         if (paddr == urbs_pkg::ADDR_FMT) begin
            fmt_r <= pwdata[7:0] & urbs_pkg::FMT_WMASK;
         end
      end
   end

   // frame is stored on its first stop bit, or later from hold once space frees
   assign fe_now = (state_r == urbs_pkg::ST_STOP) ? !rx_bit_value : fe_hold_r;
   assign wr_en = rxen && room && (((state_r == urbs_pkg::ST_STOP) && rx_bit_strobe) ||
                                   (state_r == urbs_pkg::ST_HOLD));
   assign wr_data = {fe_now, dor_pend_r, upe_hold_r, shr_r};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_r <= urbs_pkg::ST_IDLE;
         shr_r <= 9'h000;
         bit_cnt_r <= 4'h0;
         par_acc_r <= 1'b0;
         upe_hold_r <= 1'b0;
         fe_hold_r <= 1'b0;
      end else if (!rxen) begin
         state_r <= urbs_pkg::ST_IDLE;
      end else begin
         unique case (state_r)
            urbs_pkg::ST_IDLE: begin
               if (rx_start_det) begin
                  state_r <= urbs_pkg::ST_DATA;
                  shr_r <= 9'h000;
                  bit_cnt_r <= 4'h0;
                  par_acc_r <= 1'b0;
                  upe_hold_r <= 1'b0;
               end
            end
            urbs_pkg::ST_DATA: begin
               if (rx_bit_strobe) begin
                  shr_r[bit_cnt_r] <= rx_bit_value;
                  par_acc_r <= par_acc_r ^ rx_bit_value;
                  bit_cnt_r <= bit_cnt_r + 4'h1;
                  if (bit_cnt_r == char_bits(size_code) - 4'h1) begin
                     state_r <= upm1 ? urbs_pkg::ST_PAR : urbs_pkg::ST_STOP;
                  end
               end
            end
            urbs_pkg::ST_PAR: begin
               if (rx_bit_strobe) begin
                  // odd select flips the expected total
                  upe_hold_r <= upm1 && (par_acc_r ^ rx_bit_value ^ fmt_r[urbs_pkg::FMT_UPM0]);
                  state_r <= urbs_pkg::ST_STOP;
               end
            end
            urbs_pkg::ST_STOP: begin
               // a second stop bit is never awaited; stop_bits_select is ignored
               if (rx_bit_strobe) begin
                  fe_hold_r <= !rx_bit_value;
                  state_r <= room ? urbs_pkg::ST_IDLE : urbs_pkg::ST_HOLD;
               end
            end
            urbs_pkg::ST_HOLD: begin
               // frames arriving while a character waits here are lost
               if (room) begin
                  state_r <= urbs_pkg::ST_IDLE;
               end
            end
            default: state_r <= urbs_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dor_pend_r <= 1'b0;
      end else if (!rxen) begin
         dor_pend_r <= 1'b0;
      end else if ((state_r == urbs_pkg::ST_HOLD) && !room && rx_start_det) begin
         dor_pend_r <= 1'b1;
      end else if (wr_en) begin
         dor_pend_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= 2'h0;
         wptr_r <= 1'b0;
         rptr_r <= 1'b0;
      end else if (!rxen) begin
         count_r <= 2'h0;
         wptr_r <= 1'b0;
         rptr_r <= 1'b0;
      end else begin
         if (wr_en) begin
            wptr_r <= !wptr_r;
         end
         if (pop) begin
            rptr_r <= !rptr_r;
         end
         count_r <= count_r + {1'b0, wr_en} - {1'b0, pop};
      end
   end

   // head follows a buffer write one cycle late; a read captured in that very cycle may show stale flags
   urbs_rx_mem u_mem (
      .pclk(pclk),
      .presetn(presetn),
      .wr_en(wr_en),
      .wr_addr(wptr_r),
      .wr_data(wr_data),
      .rd_addr(rptr_r),
      .rd_data(head)
   );

   // error flags take no part in the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_irq <= 1'b0;
         rx_pin_override <= 1'b0;
      end else begin
         rx_irq <= rxc && csb_r[urbs_pkg::CSB_RXCIE] && global_irq_enable;
         rx_pin_override <= rxen;
      end
   end

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_rxc_flag;
      (access && !pready && !pwrite && paddr == urbs_pkg::ADDR_CSA)
         |=> prdata[urbs_pkg::CSA_RXC] == $past(count_r != 2'h0);
   endproperty
   a_rxc_flag: assert property (p_rxc_flag) else $error("receive-complete read mismatch");

   property p_flush;
      !rxen |=> (count_r == 2'h0) && (state_r == urbs_pkg::ST_IDLE);
   endproperty
   a_flush: assert property (p_flush) else $error("buffer not flushed on disable");

   property p_irq;
      ##1 rx_irq == $past(count_r != 2'h0 && csb_r[urbs_pkg::CSB_RXCIE] && global_irq_enable);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt request wrong");

   property p_irq_no_err;
      rx_irq |-> $past(count_r) != 2'h0;
   endproperty
   a_irq_no_err: assert property (p_irq_no_err) else $error("interrupt without character");

   property p_pop;
      pop |=> rptr_r != $past(rptr_r);
   endproperty
   a_pop: assert property (p_pop) else $error("data read did not advance buffer");

   property p_empty_read;
      (fire && !pwrite && paddr == urbs_pkg::ADDR_DATA && count_r == 2'h0 && !wr_en)
         |=> $stable(rptr_r) && count_r == 2'h0 && $stable(dor_pend_r);
   endproperty
   a_empty_read: assert property (p_empty_read) else $error("empty read changed state");

   property p_overrun;
      (rxen && state_r == urbs_pkg::ST_HOLD && count_r == urbs_pkg::CNT_FULL && rx_start_det) |=> dor_pend_r;
   endproperty
   a_overrun: assert property (p_overrun) else $error("overrun not flagged");

   property p_dor_clear;
      (wr_en && rxen && !(state_r == urbs_pkg::ST_HOLD && !room && rx_start_det)) |=> !dor_pend_r;
   endproperty
   a_dor_clear: assert property (p_dor_clear) else $error("overrun not cleared on transfer");

   property p_upe_off;
      (access && !pready && !pwrite && paddr == urbs_pkg::ADDR_CSA && !upm1) |=> !prdata[urbs_pkg::CSA_UPE];
   endproperty
   a_upe_off: assert property (p_upe_off) else $error("parity error shown while disabled");

   property p_store;
      (rxen && state_r == urbs_pkg::ST_STOP && rx_bit_strobe && room)
         |=> count_r == $past(count_r) + 2'h1 - {1'b0, $past(pop)};
   endproperty
   a_store: assert property (p_store) else $error("frame not buffered on stop bit");

   property p_override;
      ##1 rx_pin_override == $past(csb_r[urbs_pkg::CSB_RXEN]);
   endproperty
   a_override: assert property (p_override) else $error("pin override wrong");

   property p_fe_store;
      (wr_en && state_r == urbs_pkg::ST_STOP && count_r == 2'h0)
         |-> ##2 head[urbs_pkg::ENT_FE] == !$past(rx_bit_value, 2);
   endproperty
   a_fe_store: assert property (p_fe_store) else $error("frame error not buffered from stop bit");

   property p_short_zero;
      (wr_en && state_r == urbs_pkg::ST_STOP && size_code == 3'h0) |-> wr_data[urbs_pkg::ENT_B8:5] == 4'h0;
   endproperty
   a_short_zero: assert property (p_short_zero) else $error("unused high data bits not zero");

   property p_flags_locked;
      (wr_fire && paddr == urbs_pkg::ADDR_CSA && rxen && !rx_bit_strobe && !rx_start_det && !wr_en)
         |=> $stable(dor_pend_r) && $stable(upe_hold_r) && $stable(fe_hold_r);
   endproperty
   a_flags_locked: assert property (p_flags_locked) else $error("status write altered error flags");
endmodule

/* tb/urbs_rx_sender.sv */
// behavioural remote transmitter, seen at the output of the bit sampler
module urbs_rx_sender (
   input wire logic pclk,
   output logic rx_start_det,
   output logic rx_bit_strobe,
   output logic rx_bit_value
);
   timeunit 1ns;
   timeprecision 1ns;

   initial begin
      rx_start_det = 1'b0;
      rx_bit_strobe = 1'b0;
      rx_bit_value = 1'b1;
   end

   // n data bits lsb first, optional parity bit, first stop bit only; g >= 1 idle cycles per bit
   task automatic send(input logic [8:0] d, input int n, input logic pe, input logic pb, input logic sb,
      input int g);
      logic v;
      @(posedge pclk);
      rx_start_det <= 1'b1;
      @(posedge pclk);
      rx_start_det <= 1'b0;
      for (int i = 0; i <= n + 1; i++) begin
         v = (i < n) ? d[i] : ((i == n) ? pb : sb);
         if (i == n && !pe)
            continue;
         repeat (g) @(posedge pclk);
         rx_bit_strobe <= 1'b1;
         rx_bit_value <= v;
         @(posedge pclk);
         rx_bit_strobe <= 1'b0;
         // outside the strobe the line shows the inverse, so a stale bit is never mistaken
         rx_bit_value <= ~v;
      end
   endtask
endmodule

/* tb/urbs_rx_status_tb.sv */
// self-checking bench for the receive buffer and status block
module urbs_rx_status_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic global_irq_enable = 1'b1;
   logic [31:0] prdata;
   logic pready, pslverr, rx_irq, rx_pin_override, rx_start_det, rx_bit_strobe, rx_bit_value;
   int errors = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [32:0] exp_q[$];
   logic [8:0] d[4];

   always #50 pclk = ~pclk;

   urbs_rx_status dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_start_det(rx_start_det), .rx_bit_strobe(rx_bit_strobe), .rx_bit_value(rx_bit_value),
      .global_irq_enable(global_irq_enable), .rx_irq(rx_irq), .rx_pin_override(rx_pin_override));
   urbs_rx_sender u_tx (.pclk(pclk), .rx_start_det(rx_start_det), .rx_bit_strobe(rx_bit_strobe),
      .rx_bit_value(rx_bit_value));

   task automatic chk(input string what, input logic [32:0] e, input logic [32:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", what, e, g);
      end
   endtask

   task automatic chk_irq(input logic e);
      cmp_count++;
      if (rx_irq !== e) begin
         errors++;
         $display("unexpected irq: expected %b, seen %b", e, rx_irq);
      end
   endtask

   task automatic chk_pin(input logic e);
      cmp_count++;
      if (rx_pin_override !== e) begin
         errors++;
         $display("unexpected override: expected %b, seen %b", e, rx_pin_override);
      end
   endtask

   task automatic give_verdict();
      $display("comparisons %0d, errors %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // a read is judged at the rising edge that completes it, on the values sampled there
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite)
         chk("read", exp_q.pop_front(), {pslverr, prdata});
   end

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         give_verdict();
      end
   end

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic [32:0] e);
      if (!w)
         exp_q.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      // request stands until a rising edge samples pready high; only the bench timeout ends a hang
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] v);
      apb(1'b1, a, {24'h00_0000, v}, 33'h0_0000_0000);
   endtask

   task automatic rd(input logic [11:0] a, input logic [32:0] e);
      apb(1'b0, a, 32'h0000_0000, e);
   endtask

   task automatic settle();
      repeat (4) @(negedge pclk);
   endtask

   initial begin
      logic [8:0] x;
      logic [7:0] f;
      int n;
      void'($urandom(32'h16be_33fb));
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      settle();
      chk_pin(1'b0);
      rd(urbs_pkg::ADDR_CSB, urbs_pkg::CSB_RST);
      rd(urbs_pkg::ADDR_FMT, urbs_pkg::FMT_RST);
      rd(12'h010, 33'h1_0000_0000);
      wr(urbs_pkg::ADDR_CSB, 8'h90);
      settle();
      chk_pin(1'b1);
      // parity off with no parity bit sent, then even and odd each with a good and a corrupted parity bit
      for (int i = 0; i < 6; i++) begin
         f = (i < 2) ? 8'h06 : ((i < 4) ? 8'h26 : 8'h36);
         wr(urbs_pkg::ADDR_FMT, f);
         x = 9'($urandom_range(255));
         u_tx.send(x, 8, f[5], (^x[7:0]) ^ f[4] ^ i[0], 1'b1, 1 + i % 3);
         settle();
         chk_irq(1'b1);
         rd(urbs_pkg::ADDR_CSA, {f[5] & i[0], 2'b00} | 8'h80);
         rd(urbs_pkg::ADDR_DATA, x[7:0]);
         settle();
         chk_irq(1'b0);
      end
      // framing and parity error with the interrupt enable off
      wr(urbs_pkg::ADDR_CSB, 8'h10);
      wr(urbs_pkg::ADDR_FMT, 8'h26);
      x = 9'($urandom_range(255));
      u_tx.send(x, 8, 1'b1, ~^x[7:0], 1'b0, 2);
      settle();
      chk_irq(1'b0);
      rd(urbs_pkg::ADDR_CSA, 8'h94);
      wr(urbs_pkg::ADDR_CSA, 8'h00);
      wr(urbs_pkg::ADDR_DATA, 8'h5a);
      wr(urbs_pkg::ADDR_FMT, 8'h0e);
      rd(urbs_pkg::ADDR_CSA, 8'h90);
      rd(urbs_pkg::ADDR_DATA, x[7:0]);
      // two buffered, one held, a fourth start while full
      wr(urbs_pkg::ADDR_CSB, 8'h90);
      wr(urbs_pkg::ADDR_FMT, 8'h06);
      for (int i = 0; i < 4; i++) begin
         d[i] = 9'($urandom_range(255));
         u_tx.send(d[i], 8, 1'b0, 1'b0, 1'b1, 1);
      end
      @(posedge pclk);
      global_irq_enable <= 1'b0;
      settle();
      chk_irq(1'b0);
      @(posedge pclk);
      global_irq_enable <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         rd(urbs_pkg::ADDR_CSA, (i == 2) ? 8'h88 : 8'h80);
         rd(urbs_pkg::ADDR_DATA, d[i][7:0]);
      end
      u_tx.send(d[3], 8, 1'b0, 1'b0, 1'b1, 2);
      settle();
      rd(urbs_pkg::ADDR_CSA, 8'h80);
      rd(urbs_pkg::ADDR_DATA, d[3][7:0]);
      rd(urbs_pkg::ADDR_DATA, 8'h00);
      rd(urbs_pkg::ADDR_CSA, 8'h00);
      // size codes 0..3 and the nine-bit code
      for (int c = 0; c < 5; c++) begin
         n = (c < 4) ? 5 + c : 9;
         wr(urbs_pkg::ADDR_CSB, (c < 4) ? 8'h90 : 8'h94);
         // two stop bits selected, yet only the first is ever sent
         wr(urbs_pkg::ADDR_FMT, (c < 4) ? 8'((c << 1) | 8) : 8'h0e);
         x = 9'($urandom());
         u_tx.send(x, n, 1'b0, 1'b0, 1'b1, 3);
         settle();
         rd(urbs_pkg::ADDR_CSB, (c < 4) ? 8'h90 : {6'b100101, x[8], 1'b0});
         rd(urbs_pkg::ADDR_DATA, x[7:0] & 8'((1 << n) - 1));
      end
      // flush on disable, and a reception abandoned midway
      wr(urbs_pkg::ADDR_FMT, 8'h06);
      wr(urbs_pkg::ADDR_CSB, 8'h90);
      u_tx.send(d[0], 8, 1'b0, 1'b0, 1'b1, 1);
      u_tx.send(d[1], 8, 1'b0, 1'b0, 1'b1, 1);
      wr(urbs_pkg::ADDR_CSB, 8'h80);
      settle();
      chk_irq(1'b0);
      chk_pin(1'b0);
      wr(urbs_pkg::ADDR_CSB, 8'h90);
      rd(urbs_pkg::ADDR_CSA, 8'h00);
      u_tx.send(d[2], 3, 1'b0, 1'b0, 1'b1, 1);
      wr(urbs_pkg::ADDR_CSB, 8'h80);
      wr(urbs_pkg::ADDR_CSB, 8'h90);
      x = 9'($urandom_range(255));
      u_tx.send(x, 8, 1'b0, 1'b0, 1'b1, 2);
      settle();
      rd(urbs_pkg::ADDR_CSA, 8'h80);
      rd(urbs_pkg::ADDR_DATA, x[7:0]);
      settle();
      give_verdict();
   end
endmodule
